// *** hw/load_shed_ctrl.v ***
// Summary of operation
// - above active limit, shed controlled loads until total falls to limit
// - 8192 second running average above 80 percent of rating lowers limit to 80 percent
// - average back below 80 percent restores full 30 or 20 amp limit
// - reduced limit active lights the readout decimal point
// - shed order comes from configuration switches 1 to 3
// - switch 4 off manages load while generator runs, else unmanaged
// - generator limit is 20 amps with switch 5 on, 30 amps off
// - switches 6 to 8 are ignored
// - five relays exist, only four are controlled per configuration
// - at power-up relays come on one second apart while current is watched
// - overcurrent sheds most recent load and stores the current drop
// - every shed overwrites that load's learned current
// - re-enable only when headroom below limit covers learned value
// - a shed load stays off at least two minutes
// - LED flashes while held off with headroom, steady once energized
// - four load LEDs lit while their load has power
// - readout normally shows measured total current
// - rating starts at 30 amps, indicator lit in 30 amp mode
// - short button press toggles between 30 and 20 amps
// - two second press and release enters learned value view
// - view cycle includes average step when reduced limit active
// - five seconds without press leaves the view
// - switches 1 to 5 ship on; no hardware default beyond pin levels
// - switch pattern selects one of eight fixed relay sequences
`timescale 1ns/10ps
`include "load_shed_defs.vh"
module load_shed_ctrl #(
    parameter MS_CYCLES = `CLK_HZ / 1000 * `TICK_MS_TIME
) (
    input wire core_clk,
    input wire srst,
    input wire [7:0] sensor_amps,
    input wire sensor_valid,
    input wire [7:0] config_switch_bank,
    input wire gen_run,
    input wire select_button_n,
    output reg [4:0] relay_on,
    output reg [3:0] load_led,
    output reg rating_30_led,
    output reg [3:0] display_tens,
    output reg [3:0] display_ones,
    output reg display_dp,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr
);
    localparam ST_RUN = 1'b0;
    localparam ST_SETTLE = 1'b1;

    // ------------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------------
    function [2:0] slot_relay;
        input [2:0] col;
        input [1:0] slot;
        reg [11:0] word;
        begin
            case (col)
                3'd0: word = `ORDER_COL0;
                3'd1: word = `ORDER_COL1;
                3'd2: word = `ORDER_COL2;
                3'd3: word = `ORDER_COL3;
                3'd4: word = `ORDER_COL4;
                3'd5: word = `ORDER_COL5;
                3'd6: word = `ORDER_COL6;
                default: word = `ORDER_COL7;
            endcase
            slot_relay = word[slot * 3 +: 3];
        end
    endfunction

    // lowest slot that is on: the most recently energized
    function [1:0] first_on;
        input [3:0] on;
        begin
            if (on[0]) first_on = 2'd0;
            else if (on[1]) first_on = 2'd1;
            else if (on[2]) first_on = 2'd2;
            else first_on = 2'd3;
        end
    endfunction

    // highest slot that is off: next to come back
    function [1:0] last_off;
        input [3:0] on;
        begin
            if (!on[3]) last_off = 2'd3;
            else if (!on[2]) last_off = 2'd2;
            else if (!on[1]) last_off = 2'd1;
            else last_off = 2'd0;
        end
    endfunction

    function [3:0] tens_of;
        input [7:0] v;
        reg [7:0] s;
        reg [7:0] q;
        begin
            s = (v > `DISPLAY_MAX_A) ? `DISPLAY_MAX_A : v;
            q = s / 8'd10;
            tens_of = q[3:0];
        end
    endfunction

    function [3:0] ones_of;
        input [7:0] v;
        reg [7:0] s;
        reg [7:0] q;
        begin
            s = (v > `DISPLAY_MAX_A) ? `DISPLAY_MAX_A : v;
            q = s % 8'd10;
            ones_of = q[3:0];
        end
    endfunction

    // ------------------------------------------------------------------------
    // pin synchronisers and tick dividers
    // ------------------------------------------------------------------------
    reg [9:0] pin_meta_r;
    reg [9:0] pin_sync_r;
    reg [31:0] div_r;
    reg [9:0] ms_in_s_r;
    reg ms_tick_r;
    reg sec_tick_r;
    wire [7:0] sw = pin_sync_r[7:0];
    wire gen_s = pin_sync_r[8];
    wire btn_down = ~pin_sync_r[9];

    always @(posedge core_clk) begin
        if (srst) begin
            pin_meta_r <= 10'h200;
            pin_sync_r <= 10'h200;
            div_r <= 32'h00000000;
            ms_in_s_r <= 10'h000;
            ms_tick_r <= 1'b0;
            sec_tick_r <= 1'b0;
        end else begin
            pin_meta_r <= {select_button_n, gen_run, config_switch_bank};
            pin_sync_r <= pin_meta_r;
            ms_tick_r <= 1'b0;
            sec_tick_r <= 1'b0;
            if (div_r == MS_CYCLES - 1) begin
                div_r <= 32'h00000000;
                ms_tick_r <= 1'b1;
                if (ms_in_s_r == `MS_PER_S - 10'd1) begin
                    ms_in_s_r <= 10'h000;
                    sec_tick_r <= 1'b1;
                end else begin
                    ms_in_s_r <= ms_in_s_r + 10'd1;
                end
            end else begin
                div_r <= div_r + 32'd1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // current, average and limit selection
    // ------------------------------------------------------------------------
    reg [7:0] total_r;
    reg [`AVG_W-1:0] avg_acc_r;
    reg avg_mode_r;
    reg service_20_r;
    reg manage_en_r;
    wire [7:0] avg_amps = avg_acc_r[`AVG_W-1:`AVG_SHIFT];
    wire [2:0] order_col = ~sw[`SW_ORDER_3:`SW_ORDER_1];
    wire gen_managed = gen_s & ~sw[`SW_GEN_NO_MGMT];
    wire rate_20 = gen_s ? sw[`SW_GEN_20A] : service_20_r;
    wire [7:0] reduced = rate_20 ? `LIMIT_20_RED_A : `LIMIT_30_RED_A;
    wire [7:0] limit = avg_mode_r ? reduced : (rate_20 ? `LIMIT_20_A : `LIMIT_30_A);
    wire managed = manage_en_r & (~gen_s | gen_managed);

    always @(posedge core_clk) begin
        if (srst) begin
            total_r <= 8'h00;
            avg_acc_r <= {`AVG_W{1'b0}};
            avg_mode_r <= 1'b0;
        end else begin
            if (sensor_valid) begin
                total_r <= sensor_amps;
            end
            if (sec_tick_r) begin
                avg_acc_r <= avg_acc_r - (avg_acc_r >> `AVG_SHIFT) + {{(`AVG_W-8){1'b0}}, total_r};
            end
            if (avg_amps > reduced) begin
                avg_mode_r <= 1'b1;
            end else if (avg_amps < reduced) begin
                avg_mode_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // shed and re-enable engine
    // ------------------------------------------------------------------------
    reg state_r;
    reg [3:0] slot_on_r;
    reg [1:0] shed_slot_r;
    reg [7:0] before_r;
    reg [9:0] settle_r;
    reg mem_wr_r;
    reg [7:0] mem_wdata_r;
    reg [2:0] view_idx_r;
    reg view_r;
    wire [7:0] cand_learned;
    wire [7:0] view_learned;
    wire [3:0] hold_busy;
    wire [1:0] cand = last_off(slot_on_r);
    wire [1:0] victim = first_on(slot_on_r);
    wire over = total_r > limit;
    wire headroom_ok = (limit > total_r) && ((limit - total_r) >= cand_learned);
    wire shed_go = (state_r == ST_RUN) && managed && over && (slot_on_r != 4'h0);

    always @(posedge core_clk) begin
        if (srst) begin
            state_r <= ST_RUN;
            slot_on_r <= 4'h0;
            shed_slot_r <= 2'd0;
            before_r <= 8'h00;
            settle_r <= 10'h000;
            mem_wr_r <= 1'b0;
            mem_wdata_r <= 8'h00;
        end else begin
            mem_wr_r <= 1'b0;
            if (!managed) begin
                slot_on_r <= 4'hF;
                state_r <= ST_RUN;
            end else begin
                case (state_r)
                    ST_RUN: begin
                        if (shed_go) begin
                            slot_on_r[victim] <= 1'b0;
                            shed_slot_r <= victim;
                            before_r <= total_r;
                            settle_r <= `SETTLE_MS;
                            state_r <= ST_SETTLE;
                        end else if (sec_tick_r && !over && slot_on_r != 4'hF && !hold_busy[cand] && headroom_ok) begin
                            slot_on_r[cand] <= 1'b1;
                        end
                    end
                    ST_SETTLE: begin
                        if (settle_r == 10'h000) begin
                            mem_wr_r <= 1'b1;
                            mem_wdata_r <= (before_r > total_r) ? before_r - total_r : 8'h00;
                            state_r <= ST_RUN;
                        end else if (ms_tick_r) begin
                            settle_r <= settle_r - 10'd1;
                        end
                    end
                    default: state_r <= ST_RUN;
                endcase
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < `NUM_SLOTS; g = g + 1) begin : gen_hold
            reg [6:0] hold_r;
            always @(posedge core_clk) begin
                if (srst) begin
                    hold_r <= 7'h00;
                end else if (shed_go && victim == g) begin
                    hold_r <= `SHED_HOLD_S + 7'd1;
                end else if (sec_tick_r && hold_r != 7'h00) begin
                    hold_r <= hold_r - 7'd1;
                end
            end
            assign hold_busy[g] = (hold_r != 7'h00);
        end
    endgenerate

    learned_mem u_learned (
        .core_clk(core_clk),
        .srst(srst),
        .wr_en(mem_wr_r),
        .wr_addr(shed_slot_r),
        .wr_data(mem_wdata_r),
        .rd_addr_a(cand),
        .rd_data_a(cand_learned),
        .rd_addr_b(view_idx_r[1:0]),
        .rd_data_b(view_learned)
    );

    // ------------------------------------------------------------------------
    // service select button and stored value view
    // ------------------------------------------------------------------------
    reg btn_prev_r;
    reg [11:0] press_ms_r;
    reg [12:0] idle_ms_r;

    always @(posedge core_clk) begin
        if (srst) begin
            btn_prev_r <= 1'b0;
            press_ms_r <= 12'h000;
            idle_ms_r <= 13'h0000;
            service_20_r <= 1'b0;
            view_r <= 1'b0;
            view_idx_r <= 3'd0;
        end else if (ms_tick_r) begin
            btn_prev_r <= btn_down;
            if (btn_down) begin
                idle_ms_r <= 13'h0000;
                if (press_ms_r != `LONG_PRESS_MS) begin
                    press_ms_r <= press_ms_r + 12'd1;
                end
            end else begin
                press_ms_r <= 12'h000;
                if (view_r && idle_ms_r == `VIEW_TIMEOUT_MS - 13'd1) begin
                    view_r <= 1'b0;
                end else if (view_r) begin
                    idle_ms_r <= idle_ms_r + 13'd1;
                end
            end
            if (btn_prev_r && !btn_down) begin
                if (view_r) begin
                    if (view_idx_r == `VIEW_AVG_IDX) begin
                        view_idx_r <= 3'd0;
                    end else if (view_idx_r == 3'd3) begin
                        view_idx_r <= avg_mode_r ? `VIEW_AVG_IDX : 3'd0;
                    end else begin
                        view_idx_r <= view_idx_r + 3'd1;
                    end
                end else if (press_ms_r == `LONG_PRESS_MS) begin
                    view_r <= 1'b1;
                    idle_ms_r <= 13'h0000;
                    if (view_idx_r == `VIEW_AVG_IDX && !avg_mode_r) begin
                        view_idx_r <= 3'd0;
                    end
                end else begin
                    service_20_r <= ~service_20_r;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // relays, indicators and readout
    // ------------------------------------------------------------------------
    reg [9:0] flash_ms_r;
    reg flash_r;
    reg [4:0] relay_nxt;
    reg [3:0] led_nxt;
    reg [7:0] shown;
    integer r;
    integer s;

    always @* begin
        relay_nxt = 5'h00;
        for (r = 0; r < `NUM_RELAYS; r = r + 1) begin
            for (s = 0; s < `NUM_SLOTS; s = s + 1) begin
                if (slot_on_r[s] && slot_relay(order_col, s[1:0]) == r[2:0]) begin
                    relay_nxt[r] = 1'b1;
                end
            end
        end
        led_nxt = slot_on_r;
        if (managed && !slot_on_r[cand] && hold_busy[cand] && headroom_ok && flash_r) begin
            led_nxt[cand] = 1'b1;
        end
        shown = total_r;
        if (view_r) begin
            led_nxt = 4'h0;
            if (view_idx_r == `VIEW_AVG_IDX) begin
                shown = avg_amps;
            end else begin
                led_nxt[view_idx_r[1:0]] = 1'b1;
                shown = view_learned;
            end
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            flash_ms_r <= 10'h000;
            flash_r <= 1'b0;
            relay_on <= 5'h00;
            load_led <= 4'h0;
            rating_30_led <= 1'b1;
            display_tens <= 4'h0;
            display_ones <= 4'h0;
            display_dp <= 1'b0;
        end else begin
            if (ms_tick_r) begin
                if (flash_ms_r == `FLASH_HALF_MS - 10'd1) begin
                    flash_ms_r <= 10'h000;
                    flash_r <= ~flash_r;
                end else begin
                    flash_ms_r <= flash_ms_r + 10'd1;
                end
            end
            relay_on <= relay_nxt;
            load_led <= led_nxt;
            rating_30_led <= ~service_20_r;
            display_tens <= tens_of(shown);
            display_ones <= ones_of(shown);
            display_dp <= avg_mode_r;
        end
    end

    // ------------------------------------------------------------------------
    // apb slave, zero wait states, read data latched in setup phase
    // ------------------------------------------------------------------------
    wire addr_ok = (paddr == `REG_CTRL) || (paddr == `REG_STATUS) || (paddr == `REG_CURRENT);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

    always @(posedge core_clk) begin
        if (srst) begin
            manage_en_r <= `CTRL_RESET;
            prdata <= 32'h00000000;
        end else begin
            if (psel && penable && pwrite && paddr == `REG_CTRL) begin
                manage_en_r <= pwdata[0];
            end
            if (psel && !penable) begin
                case (paddr)
                    `REG_CTRL: prdata <= {31'h00000000, manage_en_r};
                    `REG_STATUS: prdata <= {16'h0000, limit, gen_managed, view_r, service_20_r, avg_mode_r,
                                            slot_on_r};
                    `REG_CURRENT: prdata <= {16'h0000, avg_amps, total_r};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// *** hw/load_shed_defs.vh ***
`ifndef LOAD_SHED_DEFS_VH
`define LOAD_SHED_DEFS_VH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_HZ 50000000
`define TICK_MS_TIME 1
`define MS_PER_S 10'd1000
`define SHED_HOLD_S 7'd120
`define LONG_PRESS_MS 12'd2000
`define VIEW_TIMEOUT_MS 13'd5000
`define SETTLE_MS 10'd500
`define FLASH_HALF_MS 10'd250

// ----------------------------------------------------------------------------
// service limits in amps
// ----------------------------------------------------------------------------
`define LIMIT_30_A 8'd30
`define LIMIT_20_A 8'd20
`define LIMIT_30_RED_A 8'd24
`define LIMIT_20_RED_A 8'd16
`define DISPLAY_MAX_A 8'd99

// ----------------------------------------------------------------------------
// running average
// ----------------------------------------------------------------------------
`define AVG_SHIFT 13
`define AVG_W 21

// ----------------------------------------------------------------------------
// configuration switch bit positions (bit high = switch on)
// ----------------------------------------------------------------------------
`define SW_ORDER_1 0
`define SW_ORDER_2 1
`define SW_ORDER_3 2
`define SW_GEN_NO_MGMT 3
`define SW_GEN_20A 4

// ----------------------------------------------------------------------------
// relay codes and shed order tables, slot 0 in low bits, first to shed
// ----------------------------------------------------------------------------
`define NUM_RELAYS 5
`define NUM_SLOTS 4
`define ORDER_COL0 12'h888
`define ORDER_COL1 12'h508
`define ORDER_COL2 12'h8C8
`define ORDER_COL3 12'h458
`define ORDER_COL4 12'h858
`define ORDER_COL5 12'h518
`define ORDER_COL6 12'h88B
`define ORDER_COL7 12'h50B

// ----------------------------------------------------------------------------
// apb register map
// ----------------------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_CURRENT 8'h08
`define CTRL_RESET 1'b1
`define VIEW_AVG_IDX 3'd4

`endif

// *** hw/learned_mem.v ***
`timescale 1ns/10ps
module learned_mem (
    input wire core_clk,
    input wire srst,
    input wire wr_en,
    input wire [1:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [1:0] rd_addr_a,
    output reg [7:0] rd_data_a,
    input wire [1:0] rd_addr_b,
    output reg [7:0] rd_data_b
);
    reg [7:0] mem_r [0:3];
    integer i;

    // ------------------------------------------------------------------------
    // storage, cleared at reset so nothing is assumed about any load
    // ------------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (srst) begin
            for (i = 0; i < 4; i = i + 1) begin
                mem_r[i] <= 8'h00;
            end
            rd_data_a <= 8'h00;
            rd_data_b <= 8'h00;
        end else begin
            if (wr_en) begin
                mem_r[wr_addr] <= wr_data;
            end
            rd_data_a <= mem_r[rd_addr_a];
            rd_data_b <= mem_r[rd_addr_b];
        end
    end
endmodule

// *** bench/sensor_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// main feed current sensor
// ----------------------------------------------------------------------------
module sensor_model #(
    parameter int LOAD_A = 5
) (
    input wire core_clk,
    input wire [4:0] relay_on,
    input wire [7:0] base_amps,
    output logic [7:0] sensor_amps,
    output logic sensor_valid
);
    // every energized relay adds one fixed load to the uncontrolled base
    always @(posedge core_clk) begin
        sensor_amps <= base_amps + 8'(LOAD_A * $countones(relay_on));
        sensor_valid <= 1'b1;
    end
endmodule

// *** bench/load_shed_monitor.sv ***
`timescale 1ns/10ps
module load_shed_monitor (
    input wire core_clk,
    input wire srst,
    input wire [7:0] sensor_amps,
    input wire select_button_n,
    input wire [4:0] relay_on,
    input wire rating_30_led,
    input wire [3:0] display_tens,
    input wire [3:0] display_ones,
    input wire display_dp,
    input wire psel,
    input wire penable,
    input wire [7:0] paddr,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    wire mapped = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_pready_high: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (s_access |-> mapped || (pslverr && prdata == 32'h0))
        else $error("unmapped access without error");
    a_err_mapped: assert property (s_setup ##1 (penable && mapped) |-> !pslverr) else $error("error on mapped");
    a_err_setup: assert property (s_setup |-> !pslverr) else $error("error in setup phase");
    a_reset_state: assert property (disable iff (1'b0) srst |=> relay_on == 5'h00 && rating_30_led
        && !display_dp && display_tens == 4'h0 && display_ones == 4'h0) else $error("bad reset state");
    a_max_four: assert property ($countones(relay_on) <= 4) else $error("more than four relays");
    a_bcd_digits: assert property (display_tens <= 4'h9 && display_ones <= 4'h9) else $error("bad digit");
    a_rating_button: assert property ($changed(rating_30_led) |-> select_button_n)
        else $error("rating changed while button held");
    a_shed_cause: assert property (|($past(relay_on) & ~relay_on) |-> $past(sensor_amps, 3) > 8'd16)
        else $error("relay shed without overcurrent");
endmodule
bind load_shed_ctrl load_shed_monitor load_shed_monitor_i (.core_clk(core_clk), .srst(srst),
    .sensor_amps(sensor_amps), .select_button_n(select_button_n), .relay_on(relay_on),
    .rating_30_led(rating_30_led), .display_tens(display_tens), .display_ones(display_ones),
    .display_dp(display_dp), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));

// *** bench/load_shed_ctrl_tb_top.sv ***
`timescale 1ns/10ps
`include "load_shed_defs.vh"
module load_shed_ctrl_tb_top;
    localparam int MSC = 2;
    logic core_clk, srst, sensor_valid, gen_run, select_button_n, psel, penable, pwrite, pready, pslverr, err;
    logic rating_30_led, display_dp;
    logic [7:0] sensor_amps, config_switch_bank, paddr, base_amps;
    logic [4:0] relay_on;
    logic [3:0] load_led, display_tens, display_ones;
    logic [31:0] pwdata, prdata, rd;
    int err_total, samples_checked;

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    load_shed_ctrl #(.MS_CYCLES(MSC)) load_shed_ctrl_i (.core_clk(core_clk), .srst(srst),
        .sensor_amps(sensor_amps), .sensor_valid(sensor_valid), .config_switch_bank(config_switch_bank),
        .gen_run(gen_run), .select_button_n(select_button_n), .relay_on(relay_on), .load_led(load_led),
        .rating_30_led(rating_30_led), .display_tens(display_tens), .display_ones(display_ones),
        .display_dp(display_dp), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
    sensor_model sensor_model_i (.core_clk(core_clk), .relay_on(relay_on), .base_amps(base_amps),
        .sensor_amps(sensor_amps), .sensor_valid(sensor_valid));

    // ------------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task wait_ms(input int ms);
        repeat (ms * MSC) @(posedge core_clk);
    endtask

    // one apb transfer, entered just after a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) err_total++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task press(input int ms);
        select_button_n <= 1'b0;
        wait_ms(ms);
        select_button_n <= 1'b1;
        wait_ms(10);
    endtask

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task t_reset;
        chk(relay_on, 5'h00);
        chk({rating_30_led, display_dp, display_tens, display_ones}, 10'h200);
    endtask

    task t_powerup;
        logic [4:0] exp [4];
        exp = '{5'h10, 5'h14, 5'h16, 5'h17};
        wait_ms(500);
        for (int k = 0; k < 4; k++) begin
            wait_ms(1000);
            chk(relay_on, exp[k]);
        end
        chk({display_tens, display_ones}, 8'h25);
        chk(load_led, 4'hF);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk(rd[15:8], `LIMIT_30_A);
        apb(1'b0, `REG_CURRENT, 32'h0);
        chk(rd[7:0], 8'd25);
        apb(1'b0, 8'h0C, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask

    task t_tap_shed;
        press(100);
        chk(rating_30_led, 1'b0);
        wait_ms(600);
        chk(relay_on, 5'h16);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk(rd[15:8], `LIMIT_20_A);
        chk({display_tens, display_ones}, 8'h20);
    endtask

    task t_view;
        press(2100);
        chk({display_tens, display_ones}, 8'h05);
        chk(load_led, 4'h1);
        wait_ms(5100);
        chk({display_tens, display_ones}, 8'h20);
        chk(load_led, 4'hE);
    endtask

    task t_reserved;
        config_switch_bank <= 8'hFF;
        wait_ms(10);
        chk(relay_on, 5'h16);
        config_switch_bank <= 8'h1F;
        wait_ms(10);
    endtask

    task t_unmanaged;
        apb(1'b1, `REG_CTRL, 32'h0);
        apb(1'b0, `REG_CTRL, 32'h0);
        chk(rd[0], 1'b0);
        chk(relay_on, 5'h17);
        press(100);
        chk(rating_30_led, 1'b1);
        apb(1'b1, `REG_CTRL, 32'h1);
        wait_ms(10);
        chk(relay_on, 5'h17);
    endtask

    // ------------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------------
    initial begin
        err_total = 0;
        samples_checked = 0;
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        select_button_n = 1'b1;
        config_switch_bank = 8'h1F;
        gen_run = 1'b0;
        base_amps = 8'd5;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_powerup();
        t_tap_shed();
        t_view();
        t_reserved();
        t_unmanaged();
        tally_and_finish();
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        err_total++;
        tally_and_finish();
    end
endmodule
